// [verilog/ams_pkg.sv]
// shared constants, modes and carrier types of the converter serial control
package ams_pkg;

  // ---------------------------------------------------------------------
  // word sizes
  // ---------------------------------------------------------------------
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned CFG_BITS  = 8;
  localparam logic [4:0]  LAST_FALL = 5'h1F;   // 32nd falling edge
  localparam logic [3:0]  CFG_FULL  = 4'h8;    // config bits before use

  // ---------------------------------------------------------------------
  // config word field positions, first bit received lands in bit 7
  // ---------------------------------------------------------------------
  localparam int unsigned CFG_EN_POS  = 7;
  localparam int unsigned CFG_TMP_POS = 3;
  localparam int unsigned CFG_RJA_POS = 2;
  localparam int unsigned CFG_RJB_POS = 1;
  localparam int unsigned CFG_DBL_POS = 0;

  // ---------------------------------------------------------------------
  // output word status bits and clamp limits (sub-LSB units)
  // ---------------------------------------------------------------------
  localparam logic              EOC_BUSY  = 1'b1;
  localparam logic              EOC_DONE  = 1'b0;
  localparam logic              FIXED_LOW = 1'b0;
  localparam logic signed [32:0] RES_OVER  = 33'sh010000000;
  localparam logic signed [32:0] RES_UNDER = -33'sh010000001;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  // conversion mode as applied to the core
  typedef struct packed {
    logic temp_sel;
    logic rej_a;
    logic rej_b;
    logic dbl;
  } ams_mode_t;

  localparam ams_mode_t MODE_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

  // the three host pins after synchronising
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si_bit;
  } ams_pins_t;

  // converter cycle, gray along conv -> sleep -> output
  typedef enum logic [1:0] {
    ST_CONV  = 2'b00,
    ST_SLEEP = 2'b01,
    ST_DOUT  = 2'b11
  } ams_st_t;

  typedef struct packed {
    ams_st_t   st;
    logic      sub;
    logic      req;
    logic      rose;
    logic [3:0] rcnt;
    logic [4:0] fcnt;
    logic [7:0] cfg;
    ams_mode_t act;
    logic [31:0] smp_a;
    logic [31:0] word;
    logic      sck_d;
    logic      start;
    logic      chop;
    logic      so_bit;
    logic      oe_n;
  } ams_state_t;

endpackage : ams_pkg

// [verilog/ams_sync.sv]
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ams_sync
  import ams_pkg::*;
#(
  parameter int unsigned W = 3
)(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ---------------------------------------------------------------------
  // one chain per bit; first stage feeds only the second
  // ---------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic s1_r;
      logic s2_r;
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
        end else if (clk_en) begin
          s1_r <= d[i];
          s2_r <= s1_r;
        end
      end
      assign q[i] = s2_r;
    end
  endgenerate

endmodule : ams_sync

// [verilog/ams_fmt.sv]
// combines core samples and packs the 32-bit result word
`timescale 1ns/1ps
module ams_fmt
  import ams_pkg::*;
(
  input  wire logic [31:0] sample_a,
  input  wire logic [31:0] sample_b,
  input  wire logic        dbl,
  output logic      [31:0] word
);

  logic signed [32:0] a_x;
  logic signed [32:0] b_x;
  logic signed [32:0] diff;
  logic signed [32:0] val;
  logic        [29:0] clip;

  // ---------------------------------------------------------------------
  // offset removal, clamp, status bits
  // ---------------------------------------------------------------------
  always_comb begin
    a_x  = $signed({sample_a[31], sample_a});
    b_x  = $signed({sample_b[31], sample_b});
    // b is taken with the input reversed, so offset cancels in a-b
    diff = a_x - b_x;
    val  = dbl ? a_x : (diff >>> 1);
    // out of range clamps to the one-past-full-scale codes
    if (val > RES_OVER) begin
      clip = RES_OVER[29:0];
    end else if (val < RES_UNDER) begin
      clip = RES_UNDER[29:0];
    end else begin
      clip = val[29:0];
    end
    // sign inverted so positive reads 1; 11 over, 00 under
    word = {EOC_DONE, FIXED_LOW, ~clip[29], clip[28:0]};
  end

endmodule : ams_fmt

// [verilog/ams_ctrl.sv]
// serial-side control of the converter: modes, conversions, result shift
`timescale 1ns/1ps
// Notes on behaviour
// - temp select with enable converts temperature sensor
// - enable low keeps all previous modes
// - rejection bits: 00 both, 01 50Hz, 10 60Hz
// - speed bit selects normal or double rate
// - temperature input always runs normal speed
// - normal speed combines two conversions removing offset
// - word: three status, 24 result, five sub
// - early chip select rise aborts, starts conversion
// - end flag driven while selected, high converting
// - bit 30 always low
// - bit 29 is sign, high positive
// - bits 29,28 flag over and under range
// - out of range clamps one LSB past
// - deselected: output released, clock pulses ignored
// - bit 30 on first fall, bit 0 31st
// - 32nd fall drives output high, new conversion
// - one conversion per word, no pipeline
// - config: enable, three spare, temp, rejection, speed
// - input sampled rising, output changed falling
// - after reset external, both rejection, normal
// - release before first rise returns to sleep
module ams_ctrl
  import ams_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        cs_n_pin,
  input  wire logic        sck_pin,
  input  wire logic        serial_in,
  input  wire logic        core_done,
  input  wire logic [31:0] core_sample,
  output logic             core_start,
  output logic             core_chop,
  output logic             temp_input_select,
  output logic             rejection_bit_a,
  output logic             rejection_bit_b,
  output logic             double_rate_select,
  output logic             serial_out,
  output logic             serial_out_oe_n
);

  // ---------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------
  ams_state_t r;
  ams_state_t n;
  ams_pins_t  pin_raw;
  ams_pins_t  pin_s;
  logic       sck_rise;
  logic       sck_fall;
  logic [31:0] fmt_a;
  logic [31:0] fmt_word;

  // ---------------------------------------------------------------------
  // config decode
  // ---------------------------------------------------------------------
  // a short or disabled word, or the reserved pair, keeps the old mode
  function automatic ams_mode_t cfg_decode(
    input logic [7:0] cfg,
    input logic [3:0] nbits,
    input ams_mode_t  prev
  );
    ams_mode_t m;
    m = prev;
    if (nbits == CFG_FULL && cfg[CFG_EN_POS]
        && !(cfg[CFG_RJA_POS] && cfg[CFG_RJB_POS])) begin
      m.temp_sel = cfg[CFG_TMP_POS];
      m.rej_a    = cfg[CFG_RJA_POS];
      m.rej_b    = cfg[CFG_RJB_POS];
      // temperature input forces normal speed
      m.dbl      = cfg[CFG_DBL_POS] & ~cfg[CFG_TMP_POS];
    end
    return m;
  endfunction : cfg_decode

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  // pins come from the host's domain, so two flops before any use
  assign pin_raw.cs_n   = cs_n_pin;
  assign pin_raw.sck    = sck_pin;
  assign pin_raw.si_bit = serial_in;

  ams_sync #(
    .W       (3)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .d       (pin_raw),
    .q       (pin_s)
  );

  // edges of the synchronised serial clock
  assign sck_rise = pin_s.sck & ~r.sck_d;
  assign sck_fall = ~pin_s.sck & r.sck_d;

  // ---------------------------------------------------------------------
  // result formatting
  // ---------------------------------------------------------------------
  // second pass pairs the held first sample with the new one
  assign fmt_a = r.sub ? r.smp_a : core_sample;

  ams_fmt u_fmt (
    .sample_a (fmt_a),
    .sample_b (core_sample),
    .dbl      (r.act.dbl),
    .word     (fmt_word)
  );

  // ---------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    n       = r;
    n.start = 1'b0;
    n.sck_d = pin_s.sck;
    unique case (r.st)
      // conversion: one pass at double rate, two passes otherwise
      ST_CONV: begin
        if (!r.req) begin
          n.start = 1'b1;
          n.chop  = r.sub;
          n.req   = 1'b1;
        end else if (core_done) begin
          n.req = 1'b0;
          if (!r.sub && !r.act.dbl) begin
            n.smp_a = core_sample;
            n.sub   = 1'b1;
          end else begin
            // word built from this cycle's passes only
            n.word = fmt_word;
            n.sub  = 1'b0;
            n.st   = ST_SLEEP;
          end
        end
      end
      // sleep: result held until the host selects
      ST_SLEEP: begin
        if (!pin_s.cs_n) begin
          n.st   = ST_DOUT;
          n.rose = 1'b0;
          n.rcnt = 4'h0;
          n.fcnt = 5'h00;
        end
      end
      // data output and config input
      ST_DOUT: begin
        if (pin_s.cs_n) begin
          if (r.rose) begin
            // abort: drop the rest and convert again
            n.st  = ST_CONV;
            n.req = 1'b0;
            n.sub = 1'b0;
            n.act = cfg_decode(r.cfg, r.rcnt, r.act);
          end else begin
            n.st = ST_SLEEP;
          end
        end else begin
          if (sck_rise) begin
            n.rose = 1'b1;
            // only the first eight bits form the config word
            if (r.rcnt < CFG_FULL) begin
              n.cfg  = {r.cfg[6:0], pin_s.si_bit};
              n.rcnt = r.rcnt + 4'h1;
            end
          end
          // a fall before the first rise shifts nothing
          if (sck_fall && r.rose) begin
            // ones fill in so the 32nd fall leaves the pin high
            n.word = {r.word[30:0], EOC_BUSY};
            n.fcnt = r.fcnt + 5'h01;
            if (r.fcnt == LAST_FALL) begin
              n.st  = ST_CONV;
              n.req = 1'b0;
              n.sub = 1'b0;
              n.act = cfg_decode(r.cfg, r.rcnt, r.act);
            end
          end
        end
      end
      default: begin
        n.st = ST_CONV;
      end
    endcase
    // pin drive: released while deselected, busy flag while converting
    n.oe_n = pin_s.cs_n;
    if (n.st == ST_CONV) begin
      n.so_bit = EOC_BUSY;
    end else begin
      n.so_bit = n.word[31];
    end
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  // reset starts a conversion in the default mode at the first enable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r.st    <= ST_CONV;
      r.sub   <= 1'b0;
      r.req   <= 1'b0;
      r.rose  <= 1'b0;
      r.rcnt  <= 4'h0;
      r.fcnt  <= 5'h00;
      r.cfg   <= CFG_RST;
      r.act   <= MODE_RST;
      r.smp_a <= WORD_RST;
      r.word  <= WORD_RST;
      r.sck_d <= 1'b1;
      r.start <= 1'b0;
      r.chop  <= 1'b0;
      r.so_bit <= EOC_BUSY;
      r.oe_n  <= 1'b1;
    end else if (clk_en) begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------------
  assign core_start         = r.start;
  assign core_chop          = r.chop;
  assign temp_input_select  = r.act.temp_sel;
  assign rejection_bit_a    = r.act.rej_a;
  assign rejection_bit_b    = r.act.rej_b;
  assign double_rate_select = r.act.dbl;
  assign serial_out         = r.so_bit;
  assign serial_out_oe_n    = r.oe_n;

endmodule : ams_ctrl

// [bench/ams_ctrl_props.sv]
// concurrent checks on the converter serial control ports
`timescale 1ns/1ps
module ams_ctrl_props
  import ams_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic core_start,
  input wire logic core_chop,
  input wire logic temp_input_select,
  input wire logic rejection_bit_a,
  input wire logic rejection_bit_b,
  input wire logic double_rate_select,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // one clock domain, so one default clock and reset for all checks
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  // five edges cover the two sync flops plus the output register
  a_oe_release: assert property (cs_n_pin [*5] |-> serial_out_oe_n)
    else $error("serial output driven while deselected");
  a_oe_drive: assert property ((!cs_n_pin) [*5] |-> !serial_out_oe_n)
    else $error("serial output released while selected");
  a_start_pulse: assert property (core_start |=> !core_start)
    else $error("core start longer than one cycle");
  a_temp_normal: assert property (temp_input_select |-> !double_rate_select)
    else $error("double rate with temperature input");
  a_no_reserved: assert property (!(rejection_bit_a && rejection_bit_b))
    else $error("reserved rejection setting applied");
  a_mode_at_start: assert property (!$stable({temp_input_select,
    rejection_bit_a, rejection_bit_b, double_rate_select})
    |=> core_start && !core_chop)
    else $error("mode changed outside a conversion start");
  a_chop_normal: assert property (core_start && core_chop
    |-> !double_rate_select)
    else $error("second pass in double rate mode");
  a_chop_rise: assert property ($rose(core_chop) |-> core_start)
    else $error("second pass flag rose without a start");
  a_busy_high: assert property (core_start && !serial_out_oe_n
    |-> serial_out)
    else $error("end flag low while converting");
endmodule : ams_ctrl_props

bind ams_ctrl ams_ctrl_props chk_u (
  .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin),
  .core_start(core_start), .core_chop(core_chop),
  .temp_input_select(temp_input_select),
  .rejection_bit_a(rejection_bit_a), .rejection_bit_b(rejection_bit_b),
  .double_rate_select(double_rate_select), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n)
);

// [bench/ams_host.sv]
// host-side partner: chip select, serial clock and config stream
`timescale 1ns/1ps
module ams_host
  import ams_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  serial_out,
  input  wire logic  serial_out_oe_n,
  output logic       cs_n_pin,
  output logic       sck_pin,
  output logic       serial_in,
  output logic [31:0] rx_word,
  output logic       rx_eoc,
  output logic       rx_valid
);
  // no pull on the pin: released, it reads inverted, so a lost drive shows
  wire pin_seen = serial_out_oe_n ? ~serial_out : serial_out;
  // frames that gave up waiting for the end flag
  int  n_timeouts = 0;

  // idle: deselected, serial clock parked low between frames
  initial begin
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    serial_in = 1'b0;
    rx_word = '0;
    rx_eoc = 1'b0;
    rx_valid = 1'b0;
  end

  // one frame of nr clock pulses, 32 ns period
  task automatic xfer(input logic [7:0] cfg, input int nr);
    int k;
    k = 0;
    cs_n_pin = 1'b0;
    repeat (4) @(negedge sys_clk);
    while (pin_seen !== 1'b0 && k < 5000) begin // wait end flag low
      @(negedge sys_clk);
      k++;
    end
    if (k >= 5000)
      n_timeouts++;
    #1; // keeps the link clock off the system clock edges
    for (int i = 0; i < nr; i++) begin
      serial_in = (i < 8) ? cfg[7-i] : ~serial_in; // msb first
      #16 sck_pin = 1'b1;
      rx_word[31-i] = pin_seen; // latched on the rise
      #16 sck_pin = 1'b0;
    end
    #16 rx_eoc = pin_seen; // level after the last fall
    cs_n_pin = 1'b1;
    rx_valid = (nr == 32);
    @(negedge sys_clk);
    rx_valid = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : xfer
endmodule : ams_host

// [bench/tb_ams_ctrl.sv]
// self-checking bench for the converter serial control
`timescale 1ns/1ps
module tb_ams_ctrl;
  import ams_pkg::*;
  logic        sys_clk, rst, core_done, core_start, core_chop;
  logic [31:0] core_sample, rx_word;
  logic        temp_input_select, rejection_bit_a, rejection_bit_b;
  logic        double_rate_select, serial_out, serial_out_oe_n;
  logic        cs_n_pin, sck_pin, serial_in, rx_eoc, rx_valid;
  int          n_errors, comparisons;
  logic [31:0] lf = 32'hC40F;
  logic [31:0] word_q[$];
  ams_mode_t   mode_q[$];
  logic [63:0] smp_q[$];
  // abort and early release steps sit near the end
  logic [7:0]  cfg_t[15] = '{8'h00, 8'h82, 8'h84, 8'h81, 8'h83, 8'h85,
    8'h88, 8'h8B, 8'h8D, 8'h86, 8'h7F, 8'h81, 8'h81, 8'h80, 8'h80};
  int          nr_t[15] = '{32, 32, 32, 32, 32, 32, 32, 32, 32, 32, 32,
    0, 32, 5, 32};

  ams_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .serial_in(serial_in),
    .core_done(core_done), .core_sample(core_sample),
    .core_start(core_start), .core_chop(core_chop),
    .temp_input_select(temp_input_select),
    .rejection_bit_a(rejection_bit_a), .rejection_bit_b(rejection_bit_b),
    .double_rate_select(double_rate_select), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));
  ams_host host_u (.sys_clk(sys_clk), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .serial_in(serial_in), .rx_word(rx_word),
    .rx_eoc(rx_eoc), .rx_valid(rx_valid));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected word: offset removed in 1x, clamped one step past full scale
  function automatic logic [31:0] ew(logic [31:0] a, logic [31:0] b,
                                     logic d);
    logic signed [32:0] v;
    v = d ? $signed({a[31], a}) : $signed({a[31], a}) - $signed({b[31], b});
    if (!d)
      v = v >>> 1;
    if (v > RES_OVER)
      v = RES_OVER;
    if (v < RES_UNDER)
      v = RES_UNDER;
    return {2'b00, ~v[29], v[28:0]};
  endfunction : ew

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected word exp %h got %h", e, g);
    end
  endtask : cmp_word

  task automatic cmp_mode(input ams_mode_t e, input ams_mode_t g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected mode exp %b got %b", e, g);
    end
  endtask : cmp_mode

  task automatic close_out;
    // a frame that never saw the end flag counts as a mismatch
    n_errors += host_u.n_timeouts;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // clock, core stand-in, result watchers, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // core answers each pass after a random delay; pair popped per cycle
  initial begin
    logic [63:0] pr;
    pr = '0;
    core_done = 1'b0;
    core_sample = '0;
    forever begin
      if (core_start === 1'b1) begin
        if (core_chop === 1'b0)
          pr = smp_q.pop_front();
        lf = lfsr(lf);
        repeat (4 + lf[3:0]) @(negedge sys_clk);
        core_sample = core_chop ? pr[31:0] : pr[63:32];
        core_done = 1'b1;
        @(negedge sys_clk);
        core_done = 1'b0;
      end
      else
        @(negedge sys_clk);
    end
  end

  always @(negedge sys_clk)
    if (core_start === 1'b1 && core_chop === 1'b0)
      cmp_mode(mode_q.pop_front(), {temp_input_select, rejection_bit_a,
        rejection_bit_b, double_rate_select});

  always @(posedge rx_valid) begin
    cmp_word(word_q.pop_front(), rx_word);
    cmp_word(32'h1, {31'h0, rx_eoc});
  end

  // a hung handshake ends the run here
  initial begin
    #300000;
    n_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence: one frame per table entry
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  c;
    logic [31:0] a, b, cur;
    ams_mode_t   md;
    rst = 1'b1;
    md = MODE_RST;
    cur = ew(32'h0, 32'h0, 1'b0); // exact zero in 1x
    smp_q.push_back(64'h0);
    mode_q.push_back(MODE_RST);
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 15; i++) begin
      c = cfg_t[i];
      if (nr_t[i] == 32)
        word_q.push_back(cur); // held word, one per conversion
      if (nr_t[i] > 0) begin
        if (nr_t[i] >= 8 && c[7] && !(c[2] && c[1]))
          md = '{c[3], c[2], c[1], c[0] & ~c[3]};
        lf = lfsr(lf);
        a = $signed(lf) >>> 2;
        lf = lfsr(lf);
        b = $signed(lf) >>> 2;
        smp_q.push_back({a, b});
        mode_q.push_back(md); // new conversion after the frame
        cur = ew(a, b, md.dbl);
      end
      host_u.xfer(c, nr_t[i]);
      $display("step %0d done", i);
    end
    close_out();
  end
endmodule : tb_ams_ctrl
